// File: mrbo_pkg.sv
package mrbo_pkg;
    // ****************************************************************
    // Command decode
    // ****************************************************************
    localparam logic [2:0]  MR3_BANK         = 3'h3;
    localparam int          ADDR_W           = 15;
    localparam int          LOC_LSB          = 0;
    localparam int          ENABLE_BIT       = 2;
    localparam int          ZERO_HI          = 14;
    localparam int          ZERO_LO          = 3;
    localparam int          CHOP_OTF_BIT     = 12;
    localparam logic [1:0]  LOC_PATTERN      = 2'h0;
    localparam logic [1:0]  LOC_THERMAL      = 2'h3;
    localparam logic [1:0]  LOC_RESET        = 2'h0;
    localparam logic        ENABLE_RESET     = 1'h0;
    // ****************************************************************
    // Burst and timing
    // ****************************************************************
    localparam int          BEATS            = 8;
    localparam int          CHOP_BEATS       = 4;
    localparam logic [2:0]  LAST_BEAT        = 3'h7;
    localparam logic [2:0]  LAST_CHOP_BEAT   = 3'h3;
    localparam int          CHOP_ADVANCE_CK  = 2;
    localparam logic [3:0]  WRITE_START_DLY  = 4'h4;
    typedef enum logic [1:0] {MRBO_SRC_ARRAY, MRBO_SRC_PATTERN, MRBO_SRC_THERMAL, MRBO_SRC_RFU} mrbo_src_t;
endpackage

// File: mrbo_if.sv
interface mrbo_if;
    logic [2:0] start;
    logic       nibble;
    logic [2:0] beat;
    logic [2:0] pos;
    modport gen (input start, input nibble, input beat, output pos);
    modport user (output start, output nibble, output beat, input pos);
endinterface

// File: mrbo_order.sv
module mrbo_order (
    input  wire         clk_sys_in,
    input  wire         nrst_in,
    mrbo_if.gen         ord
);
    // ****************************************************************
    // Registered beat position
    // ****************************************************************
    logic [2:0] inter_pos;
    logic [2:0] nib_pos;
    logic [1:0] low_sum;
    logic [2:0] pos_reg;

    assign inter_pos = ord.start ^ ord.beat;                            // see R10
    assign low_sum   = 2'(ord.start[1:0] + ord.beat[1:0]);
    assign nib_pos   = {ord.start[2] ^ ord.beat[2], low_sum};           // see R11
    assign ord.pos   = pos_reg;

    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
            pos_reg <= 3'h0;
        else
            pos_reg <= ord.nibble ? nib_pos : inter_pos;                // see R06
    end
endmodule // mrbo_order

// File: mrbo_top.sv
// How it works
// R01: MRS to bank 011 with all command strobes low loads the address into register three.
// R02: Location 00 picks training pattern, 11 thermal readout, 01 and 10 reserved.
// R03: Enable bit clear reads array; set reads the selected special register.
// R04: Location is ignored while the enable bit is clear.
// R05: Controller writes zeros on address 14 down to 3.
// R06: Burst order is interleaved or nibble-sequential per the first mode register bit.
// R07: Reads start at column bits 2:0.
// R08: Eight-beat writes take beats 0 to 7 in order regardless of column.
// R09: Chopped writes use column bit 2 for half; other slots don't-care.
// R10: Interleaved read beat k comes from start xor k.
// R11: Nibble read rotates low bits within a half, then the other half.
// R12: Chopped reads give four beats, then drivers are released for four slots.
// R13: Fixed chop starts internal write two clocks earlier.
// R14: On-the-fly chop starts internal write like an eight-beat write.
module mrbo_top (
    input  wire logic        clk_sys_in,
    input  wire logic        nrst_in,
    input  wire logic        cs_n_in,
    input  wire logic        ras_n_in,
    input  wire logic        cas_n_in,
    input  wire logic        we_n_in,
    input  wire logic [2:0]  bank_in,
    input  wire logic [14:0] addr_in,
    input  wire logic        nibble_mode_in,
    input  wire logic        chop_fixed_by_mode_register_in,
    input  wire logic        chop_enable_in,
    output logic             special_register_enable_out,
    output logic [1:0]       special_register_location_out,
    output logic [1:0]       read_source_out,
    output logic             zero_field_error_out,
    output logic             beat_valid_out,
    output logic             beat_is_write_out,
    output logic [2:0]       beat_pos_out,
    output logic             dq_oe_out,
    output logic             write_start_out
);
    // ****************************************************************
    // Command decode
    // ****************************************************************
    logic       cmd_mrs;
    logic       cmd_rd;
    logic       cmd_wr;
    logic       mr3_hit;
    logic       chop_cmd;
    logic       zero_bad;
    logic       busy;
    logic [2:0] rd_start;
    logic [2:0] wr_start;
    logic [2:0] beat_reg;
    logic [2:0] start_reg;
    logic       wr_reg;
    logic       chop_reg;
    logic       act_reg;
    logic       drive_reg;
    logic       act_d_reg;
    logic       wr_d_reg;
    logic       drive_d_reg;
    logic [3:0] ws_cnt_reg;
    logic [3:0] ws_load;
    logic       en_reg;
    logic [1:0] loc_reg;
    logic       zerr_reg;
    logic       ws_reg;
    logic [1:0] src_next;
    logic [1:0] src_reg;

    assign cmd_mrs  = !cs_n_in && !ras_n_in && !cas_n_in && !we_n_in;
    assign cmd_rd   = !cs_n_in && ras_n_in && !cas_n_in && we_n_in;
    assign cmd_wr   = !cs_n_in && ras_n_in && !cas_n_in && !we_n_in;
    assign mr3_hit  = cmd_mrs && (bank_in == mrbo_pkg::MR3_BANK);                 // see R01
    assign zero_bad = |addr_in[mrbo_pkg::ZERO_HI:mrbo_pkg::ZERO_LO];              // see R05
    assign chop_cmd = chop_fixed_by_mode_register_in
                      || (chop_enable_in && !addr_in[mrbo_pkg::CHOP_OTF_BIT]);
    assign busy     = act_reg && !(beat_reg == mrbo_pkg::LAST_BEAT);
    assign rd_start = addr_in[2:0];                                               // see R07
    assign wr_start = chop_cmd ? {addr_in[2], 2'h0} : 3'h0;                       // see R08 R09
    // Fixed chop shortens the wait to internal write start by two clocks
    assign ws_load  = chop_fixed_by_mode_register_in
                      ? 4'(mrbo_pkg::WRITE_START_DLY - 4'(mrbo_pkg::CHOP_ADVANCE_CK))  // see R13
                      : mrbo_pkg::WRITE_START_DLY;                                // see R14

    // ****************************************************************
    // Register three
    // ****************************************************************
    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            en_reg   <= mrbo_pkg::ENABLE_RESET;
            loc_reg  <= mrbo_pkg::LOC_RESET;
            zerr_reg <= 1'h0;
        end
        else if (mr3_hit)
        begin
            en_reg   <= addr_in[mrbo_pkg::ENABLE_BIT];                            // see R01 R03
            loc_reg  <= addr_in[mrbo_pkg::LOC_LSB +: 2];                          // see R01 R02
            zerr_reg <= zero_bad;
        end
    end

    // Location only matters while the enable bit is set
    always_comb
    begin
        src_next = mrbo_pkg::MRBO_SRC_ARRAY;                                      // see R04
        if (en_reg)
        begin
            case (loc_reg)                                                        // see R02
                mrbo_pkg::LOC_PATTERN: src_next = mrbo_pkg::MRBO_SRC_PATTERN;
                mrbo_pkg::LOC_THERMAL: src_next = mrbo_pkg::MRBO_SRC_THERMAL;
                default:               src_next = mrbo_pkg::MRBO_SRC_RFU;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
            src_reg <= mrbo_pkg::MRBO_SRC_ARRAY;
        else
            src_reg <= src_next;                                                  // see R03
    end

    // ****************************************************************
    // Burst sequencer
    // ****************************************************************
    // A new command is only taken after the current burst has used all eight slots
    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            act_reg   <= 1'h0;
            beat_reg  <= 3'h0;
            start_reg <= 3'h0;
            wr_reg    <= 1'h0;
            chop_reg  <= 1'h0;
        end
        else if (!busy && (cmd_rd || cmd_wr))
        begin
            act_reg   <= 1'h1;
            beat_reg  <= 3'h0;
            start_reg <= cmd_wr ? wr_start : rd_start;
            wr_reg    <= cmd_wr;
            chop_reg  <= chop_cmd;
        end
        else if (act_reg)
        begin
            beat_reg <= 3'(beat_reg + 3'h1);
            act_reg  <= busy;
        end
    end

    // Writes are never reordered; reads follow the selected order
    mrbo_if ord ();
    assign ord.start  = start_reg;
    assign ord.nibble = wr_reg ? 1'b0 : nibble_mode_in;
    assign ord.beat   = wr_reg ? 3'h0 : beat_reg;

    logic [2:0] wr_beat_reg;
    mrbo_order u_order (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .ord        (ord)
    );

    // Chop: beats past the fourth release drivers or are don't-care
    always_comb
    begin
        drive_reg = act_reg && (!chop_reg || beat_reg <= mrbo_pkg::LAST_CHOP_BEAT);   // see R09 R12
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            act_d_reg   <= 1'h0;
            wr_d_reg    <= 1'h0;
            drive_d_reg <= 1'h0;
            wr_beat_reg <= 3'h0;
        end
        else
        begin
            act_d_reg   <= act_reg && drive_reg;
            wr_d_reg    <= wr_reg;
            drive_d_reg <= drive_reg && !wr_reg;                                  // see R12
            wr_beat_reg <= 3'(start_reg + beat_reg);                              // see R08 R09
        end
    end

    // ****************************************************************
    // Internal write start
    // ****************************************************************
    // Countdown starts on the write command; otf chop keeps the full delay
    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            ws_cnt_reg <= 4'h0;
            ws_reg     <= 1'h0;
        end
        else
        begin
            ws_reg <= (ws_cnt_reg == 4'h1);
            if (!busy && cmd_wr)
                ws_cnt_reg <= ws_load;                                            // see R13 R14
            else if (ws_cnt_reg != 4'h0)
                ws_cnt_reg <= 4'(ws_cnt_reg - 4'h1);
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            special_register_enable_out   <= 1'h0;
            special_register_location_out <= 2'h0;
            read_source_out               <= 2'h0;
            zero_field_error_out          <= 1'h0;
        end
        else
        begin
            special_register_enable_out   <= en_reg;
            special_register_location_out <= loc_reg;
            read_source_out               <= src_reg;
            zero_field_error_out          <= zerr_reg;
        end
    end

    always_comb
    begin
        beat_valid_out    = act_d_reg;
        beat_is_write_out = wr_d_reg;
        beat_pos_out      = wr_d_reg ? wr_beat_reg : ord.pos;                     // see R10 R11
        dq_oe_out         = drive_d_reg;
        write_start_out   = ws_reg;
    end
endmodule // mrbo_top

// File: mrbo_props.sv
// ********************************
// Port checker
// ********************************
module mrbo_props (
    input wire logic        clk_sys_in,
    input wire logic        nrst_in,
    input wire logic        cs_n_in,
    input wire logic        ras_n_in,
    input wire logic        cas_n_in,
    input wire logic        we_n_in,
    input wire logic [2:0]  bank_in,
    input wire logic [14:0] addr_in,
    input wire logic        nibble_mode_in,
    input wire logic        chop_fixed_by_mode_register_in,
    input wire logic        chop_enable_in,
    input wire logic        special_register_enable_out,
    input wire logic [1:0]  special_register_location_out,
    input wire logic [1:0]  read_source_out,
    input wire logic        zero_field_error_out,
    input wire logic        beat_valid_out,
    input wire logic        beat_is_write_out,
    input wire logic [2:0]  beat_pos_out,
    input wire logic        dq_oe_out,
    input wire logic        write_start_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    // Only reads and writes seen while no beat is out count, since busy-time ones are refused
    wire logic mr3  = !cs_n_in && !ras_n_in && !cas_n_in && !we_n_in && bank_in == 3'h3;
    wire logic col  = !cs_n_in && ras_n_in && !cas_n_in && !beat_valid_out && !dq_oe_out;
    wire logic rd   = col && we_n_in;
    wire logic wr   = col && !we_n_in;
    wire logic chop = chop_fixed_by_mode_register_in || (chop_enable_in && !addr_in[12]);
    sequence s_wr_lin;
        beat_is_write_out && beat_pos_out == 3'h0 ##7 beat_is_write_out && beat_pos_out == 3'h7;
    endsequence
    property p_load;
        mr3 |-> ##2 special_register_enable_out == $past(addr_in[2], 2)
            && special_register_location_out == $past(addr_in[1:0], 2);
    endproperty
    a_load: assert property (p_load) else $error("mode load wrong");
    property p_thermal; mr3 && addr_in[2:0] == 3'h7 |-> ##3 read_source_out == 2'h2; endproperty
    a_thermal: assert property (p_thermal) else $error("thermal source wrong");
    property p_first; rd |-> ##2 beat_valid_out && beat_pos_out == $past(addr_in[2:0], 2); endproperty
    a_first: assert property (p_first) else $error("first beat wrong");
    property p_inter; rd && !nibble_mode_in |-> ##3 beat_pos_out == ($past(addr_in[2:0], 3) ^ 3'h1); endproperty
    a_inter: assert property (p_inter) else $error("interleave wrong");
    property p_nibble;
        rd && nibble_mode_in && !chop |-> ##6 beat_pos_out == {~$past(addr_in[2], 6), $past(addr_in[1:0], 6)};
    endproperty
    a_nibble: assert property (p_nibble) else $error("nibble order wrong");
    property p_wr_lin; wr && !chop |-> ##2 s_wr_lin; endproperty
    a_wr_lin: assert property (p_wr_lin) else $error("write order wrong");
    property p_chop_rd; rd && chop |-> ##6 (!beat_valid_out && !dq_oe_out)[*4]; endproperty
    a_chop_rd: assert property (p_chop_rd) else $error("chop release wrong");
    property p_ws_fix; wr && chop_fixed_by_mode_register_in |-> ##3 write_start_out; endproperty
    a_ws_fix: assert property (p_ws_fix) else $error("early write start missing");
endmodule // mrbo_props
bind mrbo_top mrbo_props u_props (.*);

// File: mrbo_ctrl_model.sv
// ********************************
// Controller side: one command, then deselect
// ********************************
module mrbo_ctrl_model (
    input  wire logic        clk_sys_in,
    output logic [3:0]       cmd_n_out,
    output logic [2:0]       bank_out,
    output logic [14:0]      addr_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {cmd_n_out, bank_out, addr_out} = {4'hf, 3'h0, 15'h0};
    task automatic send(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a);
        @(posedge clk_sys_in);
        cmd_n_out <= c;
        bank_out  <= b;
        addr_out  <= a;
        @(posedge clk_sys_in);
        cmd_n_out <= 4'hf;
        // Deselected bus carries the inverse so a stale value cannot pass
        addr_out  <= ~a;
    endtask
endmodule // mrbo_ctrl_model

// File: mrbo_top_test.sv
// ********************************
// Bench
// ********************************
module mrbo_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_in = 1'h0;
    logic        nrst_in = 1'h0;
    logic        nibble_mode_in = 1'h0;
    logic        chop_fixed_by_mode_register_in = 1'h0;
    logic        chop_enable_in = 1'h0;
    logic [3:0]  cmd_n;
    logic [2:0]  bank_in;
    logic [14:0] addr_in;
    logic        special_register_enable_out, zero_field_error_out, beat_valid_out;
    logic        beat_is_write_out, dq_oe_out, write_start_out;
    logic [1:0]  special_register_location_out, read_source_out;
    logic [2:0]  beat_pos_out;
    int          miscompares = 0;
    int          check_count = 0;
    always #5 clk_sys_in = ~clk_sys_in;
    mrbo_ctrl_model ctrl (.clk_sys_in(clk_sys_in), .cmd_n_out(cmd_n), .bank_out(bank_in), .addr_out(addr_in));
    mrbo_top dut (.cs_n_in(cmd_n[3]), .ras_n_in(cmd_n[2]), .cas_n_in(cmd_n[1]), .we_n_in(cmd_n[0]), .*);
    task automatic chk(input string n, input logic [2:0] e, input logic [2:0] g);
        check_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic mrs(input logic [2:0] b, input logic [14:0] a, input logic [2:0] el, input logic [1:0] s, input logic z);
        ctrl.send(4'h0, b, a);
        repeat (3) @(posedge clk_sys_in);
        #1;
        chk("enable", 3'(el[2]), 3'(special_register_enable_out));
        chk("location", 3'(el[1:0]), 3'(special_register_location_out));
        chk("source", 3'(s), 3'(read_source_out));
        chk("zero field", 3'(z), 3'(zero_field_error_out));
    endtask
    // Chop code: 0 none, 1 fixed by mode register, 2 on the fly
    task automatic burst(input logic w, input logic n, input logic [1:0] c, input logic [2:0] ca);
        logic [2:0] p;
        logic       v;
        @(posedge clk_sys_in);
        nibble_mode_in <= n;
        chop_fixed_by_mode_register_in <= c[0];
        chop_enable_in <= c[1];
        ctrl.send(w ? 4'h4 : 4'h5, 3'h0, {2'h0, ~c[1], 9'h0, ca});
        // Beat k stands between the command edge plus k+1 and the next edge
        repeat (1) @(posedge clk_sys_in);
        for (int k = 0; k < 8; k++)
        begin
            v = c == 2'h0 || k < 4;
            p = w ? (c == 2'h0 ? 3'(k) : {ca[2], 2'(k)}) : (n ? {ca[2] ^ k[2], ca[1:0] + 2'(k)} : ca ^ 3'(k));
            #1;
            chk("beat valid", 3'(v), 3'(beat_valid_out));
            chk("drive enable", 3'(v && !w), 3'(dq_oe_out));
            chk("write start", 3'(w && k == (c == 2'h1 ? 1 : 3)), 3'(write_start_out));
            if (v)
            begin
                chk("beat pos", p, beat_pos_out);
                chk("beat dir", 3'(w), 3'(beat_is_write_out));
            end
            @(posedge clk_sys_in);
        end
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk_sys_in);
        nrst_in <= 1'h1;
        mrs(3'h3, 15'h0004, 3'h4, 2'h1, 1'h0);
        mrs(3'h3, 15'h0005, 3'h5, 2'h3, 1'h0);
        mrs(3'h3, 15'h0006, 3'h6, 2'h3, 1'h0);
        mrs(3'h3, 15'h0007, 3'h7, 2'h2, 1'h0);
        mrs(3'h3, 15'h0003, 3'h3, 2'h0, 1'h0);
        mrs(3'h2, 15'h0004, 3'h3, 2'h0, 1'h0);
        mrs(3'h3, 15'h0008, 3'h0, 2'h0, 1'h1);
        for (int i = 0; i < 16; i++)
        begin
            burst(1'h0, i[3], 2'h0, i[2:0]);
        end
        burst(1'h0, 1'h1, 2'h1, 3'h5);
        burst(1'h0, 1'h0, 2'h2, 3'h6);
        burst(1'h1, 1'h0, 2'h0, 3'h5);
        burst(1'h1, 1'h1, 2'h1, 3'h4);
        burst(1'h1, 1'h0, 2'h2, 3'h3);
        report_and_stop();
    end
endmodule // mrbo_top_test
